/* File: hw/pkd_pkg.sv */
/*
  constants for the port k, drive select and e-clock stretch control block.
  assumes an 8-bit register port with byte offsets as printed.
*/
package pkd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_DRIVE = 8'h0D;
  localparam logic [7:0] OFS_EBI = 8'h0E;
  localparam logic [7:0] OFS_PORT_K_VALUE = 8'h32;
  localparam logic [7:0] OFS_PORT_K_DIRECTION = 8'h33;
  localparam int BIT_DRV_A = 0;
  localparam int BIT_DRV_B = 1;
  localparam int BIT_DRV_E = 4;
  localparam int BIT_DRV_K = 7;
  localparam int BIT_STRETCH = 0;
  localparam int BIT_K7 = 7;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic STRETCH_RESET_PERIPH = 1'b0;
  localparam logic STRETCH_RESET_OTHER = 1'b1;
  localparam logic DIR_RESET = 1'b0;
  // one full e period, in bus clocks
  localparam int BUS_E_CLOCK_DIV = 4;
  localparam logic [1:0] CS_GAP_CYCLES = 2'h1;
  typedef enum logic [2:0] {
    PKD_SPECIAL_SINGLE = 3'h0,
    PKD_SPECIAL_TEST = 3'h1,
    PKD_PERIPHERAL = 3'h2,
    PKD_EMUL_NARROW = 3'h3,
    PKD_EMUL_WIDE = 3'h4,
    PKD_NORMAL_SINGLE = 3'h5,
    PKD_NORMAL_NARROW = 3'h6,
    PKD_NORMAL_WIDE = 3'h7
  } pkd_mode_type;
  typedef enum logic [1:0] {
    PKD_CS_IDLE = 2'h0,
    PKD_CS_ACTIVE = 2'h1,
    PKD_CS_GAP = 2'h2
  } pkd_cs_type;
endpackage

/* File: hw/pkd_bit_store.sv */
/*
  single stored bit with no reset, for a data latch that keeps its value over reset.
  assumes a write enable one clock wide.
*/
`timescale 1ns/1ns
module pkd_bit_store (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic d_i,
  output logic q_o
);
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      q_o <= d_i;
    end
  end
endmodule

/* File: hw/pkd_port_ctrl.sv */
/*
  drive select, e-clock stretch control and port k bit 7 with its chip-select mode.
  assumes synchronous pins, mode inputs stable, and a one-cycle register port.
*/
`timescale 1ns/1ns
module pkd_port_ctrl (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire pkd_pkg::pkd_mode_type mode_i,
  input wire logic mem_expand_emul_on_i,
  input wire logic port_k_pullup_on_i,
  input wire logic bus_stretch_i,
  input wire logic internal_access_i,
  input wire logic emul_chip_select_i,
  input wire logic [pkd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pkd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pkd_pkg::DATA_W-1:0] rdata_o,
  input wire logic pin_k7_i,
  output logic pin_k7_o,
  output logic pin_k7_oe_o,
  output logic pin_k7_pullup_o,
  output logic drive_low_a_o,
  output logic drive_low_b_o,
  output logic drive_low_e_o,
  output logic drive_low_k_o,
  output logic bus_e_clock_o,
  output logic bus_e_clock_stretch_on_o
);
  import pkd_pkg::*;

  logic is_periph;
  logic is_emul;
  logic is_single;
  logic is_special;
  logic is_expanded;
  logic drive_mapped;
  logic ebi_mapped;
  logic port_k_value_mapped;
  logic [3:0] drive_bits;
  logic bus_e_clock_stretch_on;
  logic stretch_lock;
  logic stretch_active;
  logic pin7_direction;
  logic port_k_latch;
  logic latch_we;
  logic [1:0] e_phase;
  logic e_level;
  logic e_level_d;
  logic e_fall;
  pkd_cs_type cs_state;
  pkd_cs_type next_cs_state;
  logic [1:0] gap_cnt;
  logic [DATA_W-1:0] next_rdata;

  assign is_periph = (mode_i == PKD_PERIPHERAL);
  assign is_emul = (mode_i == PKD_EMUL_NARROW) || (mode_i == PKD_EMUL_WIDE);
  assign is_single = (mode_i == PKD_SPECIAL_SINGLE) || (mode_i == PKD_NORMAL_SINGLE);
  assign is_special = (mode_i == PKD_SPECIAL_SINGLE) || (mode_i == PKD_SPECIAL_TEST);
  assign is_expanded = !is_single && !is_periph;
  assign drive_mapped = !is_emul && !is_periph;
  assign ebi_mapped = !is_periph;
  assign port_k_value_mapped = !is_periph && !(is_expanded && mem_expand_emul_on_i);

  // reduced drive bits, a b e k in order
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      drive_bits <= 4'h0;
    end else if (wr_i && drive_mapped && addr_i == OFS_DRIVE) begin
      drive_bits <= {wdata_i[BIT_DRV_K], wdata_i[BIT_DRV_E],
                     wdata_i[BIT_DRV_B], wdata_i[BIT_DRV_A]};
    end
  end

  // drive outputs do not depend on which function owns a pin
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      drive_low_a_o <= 1'b0;
      drive_low_b_o <= 1'b0;
      drive_low_e_o <= 1'b0;
      drive_low_k_o <= 1'b0;
    end else begin
      drive_low_a_o <= drive_bits[0];
      drive_low_b_o <= drive_bits[1];
      drive_low_e_o <= drive_bits[2];
      drive_low_k_o <= drive_bits[3];
    end
  end

  // stretch control with write-once lock outside special and peripheral modes; special modes take every write, peripheral none
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bus_e_clock_stretch_on <= is_periph ? STRETCH_RESET_PERIPH : STRETCH_RESET_OTHER;
      stretch_lock <= 1'b0;
    end else if (wr_i && ebi_mapped && addr_i == OFS_EBI) begin
      if (is_special) begin
        bus_e_clock_stretch_on <= wdata_i[BIT_STRETCH];
      end else if (!stretch_lock) begin
        bus_e_clock_stretch_on <= wdata_i[BIT_STRETCH];
        stretch_lock <= 1'b1;
      end
    end
  end

  assign stretch_active = bus_e_clock_stretch_on && !is_single;

  // direction bit
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pin7_direction <= DIR_RESET;
    end else if (wr_i && port_k_value_mapped && addr_i == OFS_PORT_K_DIRECTION) begin
      pin7_direction <= wdata_i[BIT_K7];
    end
  end

  assign latch_we = wr_i && port_k_value_mapped && (addr_i == OFS_PORT_K_VALUE);

  // data latch keeps its content through reset
  pkd_bit_store u_latch (
    .ref_clk_i(ref_clk_i),
    .we_i(latch_we),
    .d_i(wdata_i[BIT_K7]),
    .q_o(port_k_latch)
  );

  // e clock: divider stalled while stretch holds e high; e masked on internal cycles only while stretch is active.
  // the hold looks at the registered e and stretch so a high e never drops
  // in the cycle after a stretch request, whatever the divider pipeline holds
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      e_phase <= 2'h0;
    end else if (!(bus_e_clock_stretch_on_o && bus_stretch_i && bus_e_clock_o)) begin
      e_phase <= e_phase + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      e_level <= 1'b0;
      e_level_d <= 1'b0;
    end else begin
      e_level <= e_phase[1];
      e_level_d <= e_level;
    end
  end

  assign e_fall = e_level_d && !e_level;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bus_e_clock_o <= 1'b0;
      bus_e_clock_stretch_on_o <= 1'b0;
    end else begin
      if (bus_e_clock_stretch_on_o && bus_stretch_i && bus_e_clock_o) begin
        bus_e_clock_o <= 1'b1;
      end else begin
        bus_e_clock_o <= e_level && !(stretch_active && internal_access_i);
      end
      bus_e_clock_stretch_on_o <= stretch_active;
    end
  end

  // chip-select gap after each falling e, skipped while bus_stretch_i is high with stretch off
  always_comb begin
    next_cs_state = cs_state;
    unique case (cs_state)
      PKD_CS_IDLE: begin
        if (mem_expand_emul_on_i) begin
          next_cs_state = PKD_CS_ACTIVE;
        end
      end
      PKD_CS_ACTIVE: begin
        if (!mem_expand_emul_on_i) begin
          next_cs_state = PKD_CS_IDLE;
        end else if (e_fall && !(bus_stretch_i && !stretch_active)) begin
          next_cs_state = PKD_CS_GAP;
        end
      end
      PKD_CS_GAP: begin
        if (!mem_expand_emul_on_i) begin
          next_cs_state = PKD_CS_IDLE;
        end else if (gap_cnt == CS_GAP_CYCLES - 2'h1) begin
          next_cs_state = PKD_CS_ACTIVE;
        end
      end
      default: next_cs_state = PKD_CS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cs_state <= PKD_CS_IDLE;
      gap_cnt <= 2'h0;
    end else begin
      cs_state <= next_cs_state;
      gap_cnt <= (cs_state == PKD_CS_GAP) ? gap_cnt + 2'h1 : 2'h0;
    end
  end

  // pin drive: chip select or general-purpose
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pin_k7_o <= 1'b1;
      pin_k7_oe_o <= 1'b0;
      pin_k7_pullup_o <= 1'b0;
    end else if (mem_expand_emul_on_i) begin
      pin_k7_o <= (next_cs_state == PKD_CS_GAP) ? 1'b1 : emul_chip_select_i;
      pin_k7_oe_o <= 1'b1;
      pin_k7_pullup_o <= 1'b0;
    end else begin
      pin_k7_o <= port_k_latch;
      pin_k7_oe_o <= pin7_direction;
      pin_k7_pullup_o <= !pin7_direction && port_k_pullup_on_i;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (addr_i == OFS_DRIVE && drive_mapped) begin
      next_rdata[BIT_DRV_A] = drive_bits[0];
      next_rdata[BIT_DRV_B] = drive_bits[1];
      next_rdata[BIT_DRV_E] = drive_bits[2];
      next_rdata[BIT_DRV_K] = drive_bits[3];
    end else if (addr_i == OFS_EBI && ebi_mapped) begin
      next_rdata[BIT_STRETCH] = bus_e_clock_stretch_on;
    end else if (addr_i == OFS_PORT_K_VALUE && port_k_value_mapped) begin
      next_rdata[BIT_K7] = pin7_direction ? port_k_latch : pin_k7_i;
    end else if (addr_i == OFS_PORT_K_DIRECTION && port_k_value_mapped) begin
      next_rdata[BIT_K7] = pin7_direction;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= READ_ZERO;
    end
  end
endmodule

/* File: test/pkd_port_ctrl_asserts.sv */
/* port-level assertions for pkd_port_ctrl.
   bound to every instance; mode held stable outside reset. */
`timescale 1ns/1ns
module pkd_port_ctrl_asserts (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire pkd_pkg::pkd_mode_type mode_i,
  input wire logic mem_expand_emul_on_i,
  input wire logic port_k_pullup_on_i,
  input wire logic bus_stretch_i,
  input wire logic [pkd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pkd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [pkd_pkg::DATA_W-1:0] rdata_o,
  input wire logic pin_k7_oe_o,
  input wire logic pin_k7_pullup_o,
  input wire logic drive_low_a_o,
  input wire logic bus_e_clock_o,
  input wire logic bus_e_clock_stretch_on_o
);
  import pkd_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic e_q;
  logic [2:0] run;
  // cycles that e has kept its level
  always_ff @(posedge ref_clk_i) begin
    e_q <= bus_e_clock_o;
    run <= (resetn_i && bus_e_clock_o == e_q) ? run + 3'h1 : 3'h0;
  end
  sequence s_drv_wr;
    wr_i && addr_i == OFS_DRIVE && !(mode_i inside {PKD_PERIPHERAL, PKD_EMUL_NARROW, PKD_EMUL_WIDE});
  endsequence
  sequence s_dir_wr;
    wr_i && addr_i == OFS_PORT_K_DIRECTION && !mem_expand_emul_on_i && mode_i != PKD_PERIPHERAL;
  endsequence
  a_rd_idle_zero: assert property (!rd_i |=> rdata_o == READ_ZERO)
    else $error("read data not idle");
  a_drive_bit_follow: assert property (s_drv_wr |-> ##2 drive_low_a_o == $past(wdata_i[0], 2))
    else $error("drive select wrong");
  a_dir_sets_oe: assert property (s_dir_wr |-> ##2 pin_k7_oe_o == $past(wdata_i[7], 2))
    else $error("direction wrong");
  a_pullup_on_in: assert property ((!pin_k7_oe_o && port_k_pullup_on_i)[*3] |-> pin_k7_pullup_o)
    else $error("pull-up missing");
  a_pullup_off: assert property ((pin_k7_oe_o || !port_k_pullup_on_i)[*3] |-> !pin_k7_pullup_o)
    else $error("pull-up stray");
  a_single_no_stretch: assert property (mode_i inside {PKD_SPECIAL_SINGLE, PKD_NORMAL_SINGLE}
    |=> !bus_e_clock_stretch_on_o)
    else $error("stretch in single chip");
  a_e_free_run: assert property ((!bus_e_clock_stretch_on_o)[*6] |-> run < 3'h3)
    else $error("e stalled");
  a_e_held_high: assert property (bus_e_clock_stretch_on_o && bus_stretch_i && bus_e_clock_o
    |=> bus_e_clock_o)
    else $error("e not held");
endmodule
bind pkd_port_ctrl pkd_port_ctrl_asserts u_chk (.*);

/* File: test/pkd_pin_model.sv */
/* pad model for pin k7: resolves the pad level.
   external driver, pull-up; an undriven pad wanders. */
`timescale 1ns/1ns
module pkd_pin_model (
  input wire logic ref_clk_i,
  input wire logic pad_out_i,
  input wire logic pad_oe_i,
  input wire logic pad_pu_i,
  input wire logic ext_en_i,
  input wire logic ext_val_i,
  output logic pad_in_o
);
  logic flt = 1'b0;
  always @(posedge ref_clk_i) begin
    flt <= ~flt;
  end
  assign pad_in_o = pad_oe_i ? pad_out_i : ext_en_i ? ext_val_i : pad_pu_i | flt;
endmodule

/* File: test/port_k_drive_estretch_ctrl_tb_top.sv */
/* self-checking bench for pkd_port_ctrl with pad model.
   one 10 MHz clock; reads scored through a queue. */
`timescale 1ns/1ns
module port_k_drive_estretch_ctrl_tb_top;
  import pkd_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rd_seen = 0;
  logic mem_expand_emul_on_i = 0, port_k_pullup_on_i = 0, bus_stretch_i = 0;
  logic internal_access_i = 0, emul_chip_select_i = 1, ext_en = 0, ext_val = 0;
  logic pin_k7_i, pin_k7_o, pin_k7_oe_o, pin_k7_pullup_o, bus_e_clock_o, bus_e_clock_stretch_on_o;
  logic drive_low_a_o, drive_low_b_o, drive_low_e_o, drive_low_k_o;
  pkd_mode_type mode_i = PKD_NORMAL_WIDE;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
  logic [7:0] q[$];
  int error_cnt = 0, checks = 0, cyc = 0;
  pkd_port_ctrl u_pkd_port_ctrl (.*);
  pkd_pin_model u_pkd_pin_model (.ref_clk_i(ref_clk_i), .pad_out_i(pin_k7_o),
    .pad_oe_i(pin_k7_oe_o), .pad_pu_i(pin_k7_pullup_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_in_o(pin_k7_i));
  always #50 ref_clk_i = ~ref_clk_i;
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= ~w;
    addr_i <= a;
    wdata_i <= v;
    @(posedge ref_clk_i);
    wr_i <= 0;
    rd_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic rst(input pkd_mode_type m, input logic k);
    @(posedge ref_clk_i);
    resetn_i <= 0;
    mode_i <= m;
    mem_expand_emul_on_i <= k;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1;
  endtask
  // random bus activity keeps the e-clock logic busy
  always @(posedge ref_clk_i) begin
    bus_stretch_i <= 1'($urandom);
    internal_access_i <= 1'($urandom);
    emul_chip_select_i <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(posedge ref_clk_i) rd_seen <= rd_i;
  always @(negedge ref_clk_i) if (rd_seen) chk(rdata_o, q.pop_front());
  initial begin
    void'($urandom(99));
    rst(PKD_NORMAL_WIDE, 0);
    rd(OFS_EBI, 8'h01);
    rd(OFS_PORT_K_DIRECTION, 8'h00);
    repeat (4) begin
      d = 8'($urandom);
      bus(1, OFS_DRIVE, d);
      rd(OFS_DRIVE, d & 8'h93);
      settle();
      chk({drive_low_k_o, drive_low_e_o, drive_low_b_o, drive_low_a_o}, {d[7], d[4], d[1], d[0]});
    end
    bus(1, OFS_EBI, 8'hFE);
    rd(OFS_EBI, 8'h00);
    bus(1, OFS_EBI, 8'h01);
    rd(OFS_EBI, 8'h00);
    bus(1, OFS_PORT_K_VALUE, 8'hFF);
    bus(1, OFS_PORT_K_DIRECTION, 8'h80);
    settle();
    chk({6'h00, pin_k7_oe_o, pin_k7_o}, 8'h03);
    rd(OFS_PORT_K_VALUE, 8'h80);
    bus(1, OFS_PORT_K_DIRECTION, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ext_val <= 1'($urandom);
      ext_en <= 1;
      settle();
      rd(OFS_PORT_K_VALUE, {ext_val, 7'h00});
    end
    ext_en <= 0;
    port_k_pullup_on_i <= 1;
    settle();
    chk({7'h00, pin_k7_pullup_o}, 8'h01);
    rd(OFS_PORT_K_VALUE, 8'h80);
    rd(8'h20, 8'h00);
    rst(PKD_SPECIAL_TEST, 0);
    bus(1, OFS_PORT_K_DIRECTION, 8'h80);
    settle();
    rd(OFS_PORT_K_VALUE, 8'h80);
    bus(1, OFS_EBI, 8'h00);
    bus(1, OFS_EBI, 8'h01);
    rd(OFS_EBI, 8'h01);
    rst(PKD_PERIPHERAL, 0);
    bus(1, OFS_DRIVE, 8'hFF);
    bus(1, OFS_PORT_K_DIRECTION, 8'h80);
    rd(OFS_DRIVE, 8'h00);
    rd(OFS_EBI, 8'h00);
    rd(OFS_PORT_K_DIRECTION, 8'h00);
    rst(PKD_EMUL_WIDE, 1);
    bus(1, OFS_DRIVE, 8'hFF);
    rd(OFS_DRIVE, 8'h00);
    rd(OFS_PORT_K_VALUE, 8'h00);
    settle();
    chk({7'h00, pin_k7_oe_o}, 8'h01);
    rst(PKD_NORMAL_SINGLE, 0);
    settle();
    chk({7'h00, bus_e_clock_stretch_on_o}, 8'h00);
    tally_and_finish();
  end
endmodule
